// ### design/bma_pkg.sv
/*
  Package for the internal bus master arbiter: register map, field layout,
  reset values and the enumerations shared by the arbiter files.
  Assumes a single 100 MHz system clock and a plain register port.
*/
package bma_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_PRIO_CTRL = 4'h0;
  localparam logic [3:0] OFS_ARB_STATUS = 4'h1;

  // Field positions inside the priority control register
  localparam int POS_POLICY_LO = 0;
  localparam int POS_POLICY_HI = 1;
  localparam int POS_LEGACY_INT = 2;
  localparam int POS_LEGACY_EXT = 3;
  localparam int POS_UNUSED_DISP = 4;
  localparam int POS_COUNT_WIDTH = 5;

  // Field positions inside the status register
  localparam int POS_ST_GNT_CORE = 0;
  localparam int POS_ST_GNT_DMA = 1;
  localparam int POS_ST_RR_DMA_NEXT = 2;
  localparam int POS_ST_PARK_DMA = 3;
  localparam int POS_ST_LEGACY_ERR = 4;

  // Reset values
  localparam logic [7:0] RST_PRIO_CTRL = 8'h00;

  // Bandwidth setting that lifts the DMA above the core under round robin
  localparam logic [2:0] BW_MAXIMUM = 3'h0;

  typedef enum logic [1:0] {
    BMA_POL_ROUND_ROBIN,
    BMA_POL_PARK_CORE,
    BMA_POL_PARK_DMA,
    BMA_POL_PARK_CURRENT
  } bma_policy_t;

  typedef enum logic [1:0] {
    BMA_OWN_IDLE,
    BMA_OWN_CORE,
    BMA_OWN_DMA
  } bma_owner_t;

endpackage

// ### design/bma_regs.sv
/*
  Register file of the arbiter: the 8-bit priority control register and the
  read-only status word, with read data registered one cycle after the strobe.
  Assumes strobes are single cycle and never both high at once.
*/
`timescale 1ns/1ps
module bma_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [bma_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bma_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [bma_pkg::DATA_W-1:0] status_word,
  output logic [bma_pkg::DATA_W-1:0] reg_rdata,
  output logic [bma_pkg::DATA_W-1:0] prio_ctrl
);
  import bma_pkg::*;

  wire logic hit_ctrl = (reg_addr == OFS_PRIO_CTRL);
  wire logic hit_status = (reg_addr == OFS_ARB_STATUS);
  wire logic [DATA_W-1:0] rd_mux = hit_ctrl ? prio_ctrl :
                                   hit_status ? status_word : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prio_ctrl <= RST_PRIO_CTRL;
    end else if (reg_wr && hit_ctrl) begin
      prio_ctrl <= reg_wdata;
    end
  end

  // Unmapped reads answer zero; data stand for one cycle only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // bma_regs

// ### design/bma_grant_core.sv
/*
  Priority core of the arbiter: picks the winner of one arbitration from the
  two requests, the policy and the remembered priority state.
  Pure combinational; the caller only consults it at transfer boundaries.
*/
`timescale 1ns/1ps
module bma_grant_core (
  input wire logic core_req,
  input wire logic dma_req,
  input wire bma_pkg::bma_policy_t policy,
  input wire logic rr_dma_next,
  input wire logic park_dma,
  input wire logic dma_bw_max,
  output logic pick_core,
  output logic pick_dma
);
  import bma_pkg::*;

  logic dma_first;

  always_comb begin
    case (policy)
      BMA_POL_ROUND_ROBIN: dma_first = rr_dma_next | dma_bw_max;
      BMA_POL_PARK_CORE: dma_first = 1'b0;
      BMA_POL_PARK_DMA: dma_first = 1'b1;
      BMA_POL_PARK_CURRENT: dma_first = park_dma;
      default: dma_first = 1'b0;
    endcase
  end

  // Only one winner ever; the loser wins only when the favourite is silent
  assign pick_dma = dma_req & (dma_first | ~core_req);
  assign pick_core = core_req & ~pick_dma;

endmodule // bma_grant_core

// ### design/bma_arbiter.sv
/*
  Internal bus master arbiter between the processor core and the DMA module.
  Holds the priority control register, arbitrates at transfer boundaries and
  exports the DMA count-width select. Assumes requesters hold their request
  until granted and mark the last cycle of a transfer with a done pulse.
*/
// Behaviour
// - Bus ownership is decided between exactly two masters, core and DMA.
// - The policy comes from the low two bits of the priority control register.
// - Round robin hands top priority to the master that did not own the finished transfer.
// - Round robin starts with the core on top after reset.
// - A DMA at maximum bandwidth setting ranks above the core under round robin.
// - Policy 01 favours the core and grants DMA only while the core does not request.
// - Policy 10 favours the DMA and grants the core only while the DMA does not request.
// - Policy 11 keeps the master that last won the bus from idle on top until the other master wins from idle.
// - Under policy 11 the first master to arbitrate becomes the current master.
// - All DMA channels together form a single requester.
// - The count-width bit selects 16-bit or 24-bit DMA byte counters.
// - The priority control register is 8 bits wide and read-write.
`timescale 1ns/1ps
module bma_arbiter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [bma_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [bma_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [bma_pkg::DATA_W-1:0] reg_rdata,
  input wire logic core_req,
  input wire logic core_done,
  input wire logic dma_req,
  input wire logic dma_done,
  input wire logic [2:0] dma_bandwidth_control,
  output logic core_gnt,
  output logic dma_gnt,
  output logic dma_count_width_select,
  output logic legacy_bits_set
);
  import bma_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [DATA_W-1:0] prio_ctrl;
  logic [DATA_W-1:0] status_word;
  logic rr_dma_next;
  logic park_dma;

  bma_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .status_word(status_word),
    .reg_rdata(reg_rdata),
    .prio_ctrl(prio_ctrl)
  );

  wire bma_policy_t policy = bma_policy_t'(prio_ctrl[POS_POLICY_HI:POS_POLICY_LO]);
  wire logic legacy_any = prio_ctrl[POS_LEGACY_INT] | prio_ctrl[POS_LEGACY_EXT];

  // Unused status bits read as zero
  always_comb begin
    status_word = '0;
    status_word[POS_ST_GNT_CORE] = core_gnt;
    status_word[POS_ST_GNT_DMA] = dma_gnt;
    status_word[POS_ST_RR_DMA_NEXT] = rr_dma_next;
    status_word[POS_ST_PARK_DMA] = park_dma;
    status_word[POS_ST_LEGACY_ERR] = legacy_bits_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  bma_owner_t owner;
  bma_owner_t next_owner;
  logic pick_core;
  logic pick_dma;

  // DMA module as one requester; channel order settled inside it
  wire logic dma_bw_max = (dma_bandwidth_control == BW_MAXIMUM);

  // Owner in its done cycle has just spent its turn, so the other side leads
  wire logic rr_dma_now = (owner == BMA_OWN_CORE) ? 1'b1 :
                          (owner == BMA_OWN_DMA) ? 1'b0 : rr_dma_next;

  bma_grant_core u_pick (
    .core_req(core_req),
    .dma_req(dma_req),
    .policy(policy),
    .rr_dma_next(rr_dma_now),
    .park_dma(park_dma),
    .dma_bw_max(dma_bw_max),
    .pick_core(pick_core),
    .pick_dma(pick_dma)
  );

  // Re-arbitrate only when idle or in the done cycle of the owner
  wire logic xfer_end = (owner == BMA_OWN_CORE && core_done) ||
                        (owner == BMA_OWN_DMA && dma_done);
  wire logic boundary = (owner == BMA_OWN_IDLE) || xfer_end;
  wire logic bus_idle_now = boundary && !pick_core && !pick_dma;

  always_comb begin
    next_owner = owner;
    if (boundary) begin
      if (pick_dma) begin
        next_owner = BMA_OWN_DMA;
      end else if (pick_core) begin
        next_owner = BMA_OWN_CORE;
      end else begin
        next_owner = BMA_OWN_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      owner <= BMA_OWN_IDLE;
      core_gnt <= 1'b0;
      dma_gnt <= 1'b0;
    end else begin
      owner <= next_owner;
      core_gnt <= (next_owner == BMA_OWN_CORE);
      dma_gnt <= (next_owner == BMA_OWN_DMA);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority memory

  // Round robin: the finishing master drops to low priority
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rr_dma_next <= 1'b0;
    end else if (core_done && owner == BMA_OWN_CORE) begin
      rr_dma_next <= 1'b1;
    end else if (dma_done && owner == BMA_OWN_DMA) begin
      rr_dma_next <= 1'b0;
    end
  end

  // Park on current: priority follows whoever wins from idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      park_dma <= 1'b0;
    end else if (owner == BMA_OWN_IDLE && pick_dma) begin
      park_dma <= 1'b1;
    end else if (owner == BMA_OWN_IDLE && pick_core) begin
      park_dma <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side outputs

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dma_count_width_select <= 1'b0;
      legacy_bits_set <= 1'b0;
    end else begin
      dma_count_width_select <= prio_ctrl[POS_COUNT_WIDTH];
      legacy_bits_set <= legacy_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_one_grant: assert property (@(posedge sys_clk) disable iff (rst)
    !(core_gnt && dma_gnt))
    else $error("both masters granted");

  chk_grant_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (core_gnt && !core_done) |=> core_gnt)
    else $error("core grant dropped mid transfer");

  chk_park_core: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CORE && boundary && core_req) |=> core_gnt)
    else $error("core not favoured under park on core");

  chk_park_dma: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_DMA && boundary && dma_req) |=> dma_gnt)
    else $error("dma not favoured under park on dma");

  chk_rr_swap: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_ROUND_ROBIN && core_gnt && core_done && dma_req) |=> dma_gnt)
    else $error("round robin did not pass to dma");

  chk_rr_bw_max: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_ROUND_ROBIN && owner == BMA_OWN_IDLE && dma_req && dma_bw_max)
    |=> dma_gnt)
    else $error("max bandwidth dma lost to core");

  chk_park_cur: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CURRENT && park_dma && boundary && dma_req) |=> dma_gnt)
    else $error("current master lost priority");

  chk_rr_init: assert property (@(posedge sys_clk)
    $fell(rst) |-> !rr_dma_next)
    else $error("round robin not starting with core");

  chk_width_sel: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 dma_count_width_select == $past(prio_ctrl[POS_COUNT_WIDTH]))
    else $error("count width select not following register");

  chk_idle_none: assert property (@(posedge sys_clk) disable iff (rst)
    bus_idle_now |=> !core_gnt && !dma_gnt)
    else $error("grant without request");

  // Ownership
  chk_dma_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (dma_gnt && !dma_done) |=> dma_gnt)
    else $error("dma grant dropped mid transfer");

  chk_core_no_req: assert property (@(posedge sys_clk) disable iff (rst)
    (boundary && !core_req) |=> !core_gnt)
    else $error("core granted without request");

  chk_dma_no_req: assert property (@(posedge sys_clk) disable iff (rst)
    (boundary && !dma_req) |=> !dma_gnt)
    else $error("dma granted without request");

  chk_rst_quiet: assert property (@(posedge sys_clk)
    rst |=> (!core_gnt && !dma_gnt && prio_ctrl == RST_PRIO_CTRL))
    else $error("reset left a grant or control bits");

  // Round robin
  chk_rr_first: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_ROUND_ROBIN && owner == BMA_OWN_IDLE && !rr_dma_next && core_req
      && !dma_bw_max) |=> core_gnt)
    else $error("core not on top under round robin");

  chk_rr_dma_turn: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_ROUND_ROBIN && owner == BMA_OWN_IDLE && rr_dma_next && dma_req)
      |=> dma_gnt)
    else $error("dma turn skipped under round robin");

  chk_rr_back: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_ROUND_ROBIN && dma_gnt && dma_done && core_req && !dma_bw_max)
      |=> core_gnt)
    else $error("round robin did not pass back to core");

  chk_rr_mark_core: assert property (@(posedge sys_clk) disable iff (rst)
    (core_gnt && core_done) |=> rr_dma_next)
    else $error("core turn not recorded");

  chk_rr_mark_dma: assert property (@(posedge sys_clk) disable iff (rst)
    (dma_gnt && dma_done) |=> !rr_dma_next)
    else $error("dma turn not recorded");

  // Parking
  chk_park_core_dma: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CORE && boundary && dma_req && !core_req) |=> dma_gnt)
    else $error("dma refused while core silent");

  chk_park_dma_core: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_DMA && boundary && core_req && !dma_req) |=> core_gnt)
    else $error("core refused while dma silent");

  chk_park_first_dma: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CURRENT && owner == BMA_OWN_IDLE && dma_req && !core_req)
      |=> (dma_gnt && park_dma))
    else $error("first dma requester not made current");

  chk_park_first_core: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CURRENT && owner == BMA_OWN_IDLE && core_req && !dma_req)
      |=> (core_gnt && !park_dma))
    else $error("first core requester not made current");

  chk_park_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (policy == BMA_POL_PARK_CURRENT && !park_dma && boundary && core_req) |=> core_gnt)
    else $error("parked core lost priority");

  // Park priority may only move while nobody owns the bus
  chk_park_stay: assert property (@(posedge sys_clk) disable iff (rst)
    (owner != BMA_OWN_IDLE) |=> $stable(park_dma))
    else $error("park owner changed during a transfer");

  // Register port and side outputs
  chk_wr_lands: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr == OFS_PRIO_CTRL) |=> prio_ctrl == $past(reg_wdata))
    else $error("control write lost");

  chk_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_wr && reg_addr != OFS_PRIO_CTRL) |=> $stable(prio_ctrl))
    else $error("stray write changed control");

  chk_rd_ctrl: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == OFS_PRIO_CTRL) |=> reg_rdata == $past(prio_ctrl))
    else $error("control read data wrong");

  chk_rd_status: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == OFS_ARB_STATUS) |=> reg_rdata == $past(status_word))
    else $error("status read data wrong");

  chk_rd_unmapped: assert property (@(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr != OFS_PRIO_CTRL && reg_addr != OFS_ARB_STATUS)
      |=> reg_rdata == '0)
    else $error("unmapped read not zero");

  chk_rdata_gap: assert property (@(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside the read slot");

  chk_legacy_flag: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 legacy_bits_set == $past(legacy_any))
    else $error("legacy flag not following register");

endmodule // bma_arbiter

// ### verif/bma_master_model.sv
/*
  Requester model for one bus master (core or the whole DMA module).
  Assumes the arbiter grants with a registered level and re-arbitrates on done.
*/
`timescale 1ns/1ps
module bma_master_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic gnt,
  output logic req,
  output logic done
);
  logic [1:0] beat;
  // Request held until done; done pulses once, inside the grant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req <= 1'b0;
      done <= 1'b0;
      beat <= 2'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        req <= 1'b1;
      end
      if (gnt && !done) begin
        beat <= beat + 2'h1;
        if (beat == 2'h1) begin
          done <= 1'b1;
          req <= 1'b0;
          beat <= 2'h0;
        end
      end
    end
  end
endmodule // bma_master_model

// ### verif/bma_arbiter_test.sv
/*
  Self-checking bench for the bus master arbiter: register port and duels.
  Assumes the two requester models stand in for the core and DMA module.
*/
`timescale 1ns/1ps
module bma_arbiter_test;
  import bma_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, start_core = 1'b0, start_dma = 1'b0;
  logic [2:0] bw = 3'h2;
  logic [7:0] reg_rdata;
  logic core_req, core_done, dma_req, dma_done, core_gnt, dma_gnt, cw_sel, legacy_set;
  int err_total = 0;
  int total_checks = 0;

  bma_arbiter bma_arbiter_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_req(core_req), .core_done(core_done), .dma_req(dma_req), .dma_done(dma_done),
    .dma_bandwidth_control(bw), .core_gnt(core_gnt), .dma_gnt(dma_gnt),
    .dma_count_width_select(cw_sel), .legacy_bits_set(legacy_set));
  bma_master_model bma_master_model_inst_core (.sys_clk(sys_clk), .rst(rst),
    .start(start_core), .gnt(core_gnt), .req(core_req), .done(core_done));
  // One requester for all channels
  bma_master_model bma_master_model_inst_dma (.sys_clk(sys_clk), .rst(rst),
    .start(start_dma), .gnt(dma_gnt), .req(dma_req), .done(dma_done));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic wait_gnt(input logic [1:0] prev, output logic [1:0] g);
    g = prev;
    for (int n = 0; n < 30 && (g === prev || g === 2'h0); n++) begin
      @(posedge sys_clk);
      #1;
      g = {dma_gnt, core_gnt};
    end
  endtask
  // Mode 0: both at once, 1: DMA one cycle ahead, 2: core alone
  task automatic duel(input string name, input logic [7:0] ctrl, input logic [2:0] w,
                      input int mode, input logic [1:0] first);
    logic [1:0] g;
    wr(OFS_PRIO_CTRL, ctrl);
    bw <= w;
    @(posedge sys_clk);
    start_dma <= (mode != 2);
    start_core <= (mode != 1);
    if (mode == 1) begin
      @(posedge sys_clk);
      start_dma <= 1'b0;
      start_core <= 1'b1;
    end
    @(posedge sys_clk);
    start_dma <= 1'b0;
    start_core <= 1'b0;
    wait_gnt(2'h0, g);
    chk({name, " first grant"}, {6'h00, first}, {6'h00, g});
    if (mode != 2) begin
      wait_gnt(first, g);
      chk({name, " second grant"}, {6'h00, ~first}, {6'h00, g});
    end
    for (int n = 0; n < 30 && g !== 2'h0; n++) begin
      @(posedge sys_clk);
      #1;
      g = {dma_gnt, core_gnt};
    end
    $display("test %s done", name);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    #1;
    if (core_gnt === 1'b1 && dma_gnt === 1'b1) begin
      err_total++;
      $display("Error single owner expected 0 seen 1");
    end
  end
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_PRIO_CTRL, 8'h00, "ctrl reset");
    duel("rr start", 8'h00, 3'h2, 0, 2'h1);
    // DMA had the last turn, so core leads and only the bandwidth setting lifts the DMA here
    duel("rr maxbw", 8'h00, 3'h0, 0, 2'h2);
    duel("rr solo", 8'h00, 3'h2, 2, 2'h1);
    duel("rr swap", 8'h00, 3'h2, 0, 2'h2);
    duel("park core", 8'h01, 3'h2, 0, 2'h1);
    duel("park dma", 8'h02, 3'h2, 0, 2'h2);
    // DMA won last from idle; a lone core must take over the parking
    duel("park cur", 8'h03, 3'h2, 2, 2'h1);
    duel("park cur2", 8'h03, 3'h2, 0, 2'h1);
    duel("park cur3", 8'h03, 3'h2, 1, 2'h2);
    duel("park cur4", 8'h03, 3'h2, 0, 2'h2);
    wr(OFS_PRIO_CTRL, 8'hf1);
    rd(OFS_PRIO_CTRL, 8'hf1, "ctrl readback");
    @(posedge sys_clk);
    #1;
    chk("rdata after read", 8'h00, reg_rdata);
    chk("count width", 8'h01, {7'h00, cw_sel});
    chk("legacy flag", 8'h00, {7'h00, legacy_set});
    wr(OFS_ARB_STATUS, 8'h5a);
    rd(OFS_PRIO_CTRL, 8'hf1, "ctrl after status write");
    // Core finished last and DMA won last from idle: both memory bits set
    rd(OFS_ARB_STATUS, 8'h0c, "status after duels");
    wr(OFS_PRIO_CTRL, 8'h0c);
    rd(OFS_PRIO_CTRL, 8'h0c, "ctrl legacy");
    chk("count width", 8'h00, {7'h00, cw_sel});
    chk("legacy flag", 8'h01, {7'h00, legacy_set});
    rd(4'h9, 8'h00, "unmapped read");
    $display("test registers done");
    close_out();
  end
endmodule // bma_arbiter_test
